// file: core/alarm_trim_pkg.sv
package alarm_trim_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_ALARM_SUMMARY = 10'h2C0;
	localparam logic [9:0] IDX_ALARM_FLAG = 10'h2C1;
	localparam logic [9:0] IDX_ALARM_GATE = 10'h2C2;
	localparam logic [9:0] IDX_LANE_FLAGS = 10'h2C4;
	localparam logic [9:0] IDX_TRIM_A_DUAL = 10'h310;
	localparam logic [9:0] IDX_TRIM_B_DUAL = 10'h313;
	localparam logic [9:0] IDX_TRIM_A_SINGLE_INA = 10'h314;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int ALARM_SRC_W = 6;
	localparam int LANE_CNT = 16;
	localparam int TRIM_W = 8;
	localparam int GATE_W = 8;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int LANE_FIFO_BIT = 5;
	localparam int PLL_LOCK_BIT = 4;
	localparam int LINK_STATE_BIT = 3;
	localparam int CLOCK_REALIGN_BIT = 2;
	localparam int PHASE_ACCUM_BIT = 1;
	localparam int DIVIDER_MISMATCH_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ALARM_GATE_RESET = 8'h3F;
	localparam logic [5:0] ALARM_FLAG_RESET = 6'h3F;
	localparam logic [15:0] LANE_FLAGS_RESET = 16'hFFFF;
	localparam logic [7:0] TRIM_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_s;

	typedef struct packed {
		logic dual_channel;
		logic fg_cal_en;
		logic sample_input_pair_a;
	} conv_mode_s;

	typedef struct packed {
		logic [TRIM_W-1:0] a_dual;
		logic [TRIM_W-1:0] b_dual;
		logic [TRIM_W-1:0] a_single_ina;
	} trim_fuse_s;

	typedef struct packed {
		logic a_valid;
		logic [TRIM_W-1:0] a_value;
		logic b_valid;
		logic [TRIM_W-1:0] b_value;
	} trim_out_s;

endpackage

// file: core/alarm_mask_and_timing_trim_regs.sv
// Overview of operation
// - Lane-FIFO gate bit set keeps lane-FIFO alarm out of the summary.
// - PLL-lock gate bit set keeps PLL lock-lost alarm out of the summary.
// - Link gate bit set keeps the link alarm out of the summary.
// - Realign gate bit set keeps clock-realign alarm out of the summary.
// - Phase-accumulator gate bit set keeps phase alarm out of the summary.
// - Divider gate bit set keeps divider-mismatch alarm out of the summary.
// - Alarm gate register resets to 0x3F, upper two bits zero.
// - Lane i overflow or underflow sets lane flag bit i, sixteen lanes.
// - Writing one to a lane flag clears it; zero leaves it.
// - A lane condition still present re-sets its flag at once.
// - Writing one to the lane-FIFO status bit clears all lane flags.
// - Lane flag register resets to 0xFFFF.
// - Each trim register holds an 8-bit sampling-instant value per core and mode.
// - Trims load factory values; software reads them back and overwrites them.
// - Core A dual-channel trim applies to core A in dual-channel mode.
// - Core B dual trim applies in dual-channel mode with foreground calibration.
// - Core A single trim applies in single mode, calibration on, input pair A.
// - Summary alarm is one when any unmasked status bit is set.
// - Any lane FIFO fault sets the lane-FIFO status bit; writing one clears it.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module alarm_mask_and_timing_trim_regs
	import alarm_trim_pkg::*;
(
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire apb_req_s apb_i, // APB request
	output apb_rsp_s apb_o, // APB response
	input wire logic [ALARM_SRC_W-2:0] alarm_src_i, // Alarm events, bits 4..0
	input wire logic [LANE_CNT-1:0] lane_fifo_err_i, // Per-lane FIFO fault
	input wire trim_fuse_s fuse_i, // Factory trim values
	input wire conv_mode_s mode_i, // Converter operating mode
	output trim_out_s trim_o, // Applied trims per core
	output logic summary_alarm_o // Unmasked alarm summary
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [LANE_CNT-1:0] sticky_next(
		input logic [LANE_CNT-1:0] cur,
		input logic [LANE_CNT-1:0] set,
		input logic [LANE_CNT-1:0] clr
	);
		sticky_next = (cur & ~clr) | set;
	endfunction

	function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
		zext8 = {{(DATA_W-8){1'b0}}, v};
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [9:0] idx;
	logic aligned;
	logic setup_ph;
	logic wr_en;
	logic mapped;
	logic [7:0] alarm_gate_register;
	logic [ALARM_SRC_W-1:0] alarm_flag_register;
	logic [LANE_CNT-1:0] per_lane_fifo_flags;
	logic [TRIM_W-1:0] core_a_dual_timing_trim;
	logic [TRIM_W-1:0] core_b_dual_timing_trim;
	logic [TRIM_W-1:0] core_a_single_ina_timing_trim;
	logic trim_loaded;
	logic [ALARM_SRC_W-1:0] alarm_set;
	logic [LANE_CNT-1:0] lane_clr;
	logic [LANE_CNT-1:0] flag_clr;
	logic [LANE_CNT-1:0] next_lane_flags;
	logic [LANE_CNT-1:0] next_alarm_flags;
	logic [DATA_W-1:0] next_rdata;
	logic pending_alarm;
	logic [DATA_W-1:0] read_word;
	logic read_err;

	assign idx = apb_i.paddr[ADDR_W-1:2];
	assign aligned = (apb_i.paddr[1:0] == 2'h0);
	assign setup_ph = apb_i.psel & ~apb_i.penable;
	assign wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite & mapped;

	always_comb begin
		mapped = 1'b0;
		next_rdata = '0;
		if (aligned) begin
			case (idx)
				IDX_ALARM_SUMMARY: begin
					mapped = 1'b1;
					next_rdata = zext8({7'h00, pending_alarm});
				end
				IDX_ALARM_FLAG: begin
					mapped = 1'b1;
					next_rdata = zext8({2'h0, alarm_flag_register});
				end
				IDX_ALARM_GATE: begin
					mapped = 1'b1;
					next_rdata = zext8(alarm_gate_register);
				end
				IDX_LANE_FLAGS: begin
					mapped = 1'b1;
					next_rdata = {16'h0000, per_lane_fifo_flags};
				end
				IDX_TRIM_A_DUAL: begin
					mapped = 1'b1;
					next_rdata = zext8(core_a_dual_timing_trim);
				end
				IDX_TRIM_B_DUAL: begin
					mapped = 1'b1;
					next_rdata = zext8(core_b_dual_timing_trim);
				end
				IDX_TRIM_A_SINGLE_INA: begin
					mapped = 1'b1;
					next_rdata = zext8(core_a_single_ina_timing_trim);
				end
				default: begin
					mapped = 1'b0;
					next_rdata = '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB response: zero wait, data captured in setup
	// ----------------------------------------------------------------
	assign apb_o = '{pready: 1'b1, pslverr: read_err, prdata: read_word};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			read_word <= '0;
			read_err <= 1'b0;
		end else if (setup_ph) begin
			read_word <= apb_i.pwrite ? '0 : next_rdata;
			read_err <= ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// Alarm gate register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_gate_register <= ALARM_GATE_RESET;
		end else if (wr_en && idx == IDX_ALARM_GATE) begin
			alarm_gate_register <= apb_i.pwdata[GATE_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Alarm flag register, sticky, write one to clear, set wins
	// ----------------------------------------------------------------
	assign alarm_set = {|lane_fifo_err_i, alarm_src_i};
	assign flag_clr = (wr_en && idx == IDX_ALARM_FLAG) ?
		{10'h000, apb_i.pwdata[ALARM_SRC_W-1:0]} : '0;
	assign next_alarm_flags = sticky_next({10'h000, alarm_flag_register},
		{10'h000, alarm_set}, flag_clr);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_flag_register <= ALARM_FLAG_RESET;
		end else begin
			alarm_flag_register <= next_alarm_flags[ALARM_SRC_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Summary alarm
	// ----------------------------------------------------------------
	// Gate bit 1 removes the source from the summary
	assign pending_alarm = |(alarm_flag_register & ~alarm_gate_register[ALARM_SRC_W-1:0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			summary_alarm_o <= 1'b0;
		end else begin
			summary_alarm_o <= pending_alarm;
		end
	end

	// ----------------------------------------------------------------
	// Per-lane FIFO flags
	// ----------------------------------------------------------------
	always_comb begin
		lane_clr = '0;
		if (wr_en && idx == IDX_LANE_FLAGS) begin
			lane_clr = apb_i.pwdata[LANE_CNT-1:0];
		end
		if (wr_en && idx == IDX_ALARM_FLAG && apb_i.pwdata[LANE_FIFO_BIT]) begin
			lane_clr = '1;
		end
	end

	// Live fault overrides the clear in the same cycle
	assign next_lane_flags = sticky_next(per_lane_fifo_flags, lane_fifo_err_i, lane_clr);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_lane_fifo_flags <= LANE_FLAGS_RESET;
		end else begin
			per_lane_fifo_flags <= next_lane_flags;
		end
	end

	// ----------------------------------------------------------------
	// Timing trims: factory load once after reset, then software
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim_loaded <= 1'b0;
		end else begin
			trim_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_a_dual_timing_trim <= TRIM_RESET;
			core_b_dual_timing_trim <= TRIM_RESET;
			core_a_single_ina_timing_trim <= TRIM_RESET;
		end else if (!trim_loaded) begin
			core_a_dual_timing_trim <= fuse_i.a_dual;
			core_b_dual_timing_trim <= fuse_i.b_dual;
			core_a_single_ina_timing_trim <= fuse_i.a_single_ina;
		end else if (wr_en) begin
			if (idx == IDX_TRIM_A_DUAL) begin
				core_a_dual_timing_trim <= apb_i.pwdata[TRIM_W-1:0];
			end
			if (idx == IDX_TRIM_B_DUAL) begin
				core_b_dual_timing_trim <= apb_i.pwdata[TRIM_W-1:0];
			end
			if (idx == IDX_TRIM_A_SINGLE_INA) begin
				core_a_single_ina_timing_trim <= apb_i.pwdata[TRIM_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Trim selection per core and mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim_o <= '0;
		end else begin
			trim_o.a_valid <= 1'b0;
			trim_o.a_value <= TRIM_RESET;
			trim_o.b_valid <= 1'b0;
			trim_o.b_value <= TRIM_RESET;
			if (mode_i.dual_channel) begin
				trim_o.a_valid <= 1'b1;
				trim_o.a_value <= core_a_dual_timing_trim;
				if (mode_i.fg_cal_en) begin
					trim_o.b_valid <= 1'b1;
					trim_o.b_value <= core_b_dual_timing_trim;
				end
			end else if (mode_i.fg_cal_en && mode_i.sample_input_pair_a) begin
				trim_o.a_valid <= 1'b1;
				trim_o.a_value <= core_a_single_ina_timing_trim;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence lane_write_s;
		wr_en && idx == IDX_LANE_FLAGS;
	endsequence

	sequence fifo_status_clear_s;
		wr_en && idx == IDX_ALARM_FLAG && apb_i.pwdata[LANE_FIFO_BIT];
	endsequence

	sequence lane_clear_on_fault_s;
		lane_write_s ##0 (lane_fifo_err_i & apb_i.pwdata[LANE_CNT-1:0]) != '0;
	endsequence

	AST_GATE_RESET: assert property (
		$past(rst_i) |-> alarm_gate_register == ALARM_GATE_RESET)
		else $error("alarm gate register not 0x3F after reset");

	AST_LANE_RESET: assert property (
		$past(rst_i) |-> per_lane_fifo_flags == LANE_FLAGS_RESET)
		else $error("lane flags not 0xFFFF after reset");

	AST_SUMMARY_GATED: assert property (
		##1 summary_alarm_o ==
		$past(|(alarm_flag_register & ~alarm_gate_register[ALARM_SRC_W-1:0])))
		else $error("summary alarm disagrees with gated status");

	AST_LANE_SET: assert property (
		|lane_fifo_err_i |=> (per_lane_fifo_flags & $past(lane_fifo_err_i))
		== $past(lane_fifo_err_i))
		else $error("faulting lane flag not set");

	AST_LANE_W1C: assert property (
		lane_write_s and (lane_fifo_err_i == '0) |=>
		per_lane_fifo_flags == ($past(per_lane_fifo_flags) & ~$past(apb_i.pwdata[15:0])))
		else $error("lane flag write-one-clear wrong");

	AST_LANE_CLEAR_ALL: assert property (
		fifo_status_clear_s and (lane_fifo_err_i == '0) |=> per_lane_fifo_flags == '0)
		else $error("status write did not clear all lane flags");

	AST_FIFO_STATUS_SET: assert property (
		|lane_fifo_err_i |=> alarm_flag_register[LANE_FIFO_BIT])
		else $error("lane fault did not set status bit");

	AST_FUSE_LOAD: assert property (
		$rose(trim_loaded) |-> core_a_dual_timing_trim == $past(fuse_i.a_dual) &&
		core_b_dual_timing_trim == $past(fuse_i.b_dual) &&
		core_a_single_ina_timing_trim == $past(fuse_i.a_single_ina))
		else $error("factory trims not loaded");

	AST_TRIM_A_DUAL: assert property (
		mode_i.dual_channel |=> trim_o.a_valid && trim_o.a_value == $past(core_a_dual_timing_trim))
		else $error("core A dual trim not applied");

	AST_TRIM_B_DUAL: assert property (
		mode_i.dual_channel && mode_i.fg_cal_en |=>
		trim_o.b_valid && trim_o.b_value == $past(core_b_dual_timing_trim))
		else $error("core B dual trim not applied");

	AST_TRIM_A_SINGLE: assert property (
		!mode_i.dual_channel && mode_i.fg_cal_en && mode_i.sample_input_pair_a |=>
		trim_o.a_valid && trim_o.a_value == $past(core_a_single_ina_timing_trim))
		else $error("core A single trim not applied");

	AST_TRIM_WRITE: assert property (
		wr_en && idx == IDX_TRIM_B_DUAL && trim_loaded |=>
		core_b_dual_timing_trim == $past(apb_i.pwdata[7:0]))
		else $error("trim write lost");

	AST_LANE_RETRIP: assert property (
		lane_clear_on_fault_s |=>
		(per_lane_fifo_flags & $past(lane_fifo_err_i)) == $past(lane_fifo_err_i))
		else $error("lane flag not set again under a live fault");

	AST_LANE_HOLD: assert property (
		!wr_en && lane_fifo_err_i == '0 |=> $stable(per_lane_fifo_flags))
		else $error("lane flags changed with no fault and no write");

	AST_STATUS_CLEAR: assert property (
		fifo_status_clear_s and (lane_fifo_err_i == '0) |=>
		!alarm_flag_register[LANE_FIFO_BIT])
		else $error("lane-FIFO status bit not cleared");

	AST_TRIM_A_WRITE: assert property (
		wr_en && idx == IDX_TRIM_A_DUAL && trim_loaded |=>
		core_a_dual_timing_trim == $past(apb_i.pwdata[TRIM_W-1:0]))
		else $error("core A dual trim write lost");

	AST_TRIM_AS_WRITE: assert property (
		wr_en && idx == IDX_TRIM_A_SINGLE_INA && trim_loaded |=>
		core_a_single_ina_timing_trim == $past(apb_i.pwdata[TRIM_W-1:0]))
		else $error("core A single trim write lost");

	AST_SUMMARY_MASKED: assert property (
		alarm_gate_register[ALARM_SRC_W-1:0] == 6'h3F |=> !summary_alarm_o)
		else $error("summary alarm raised with every source gated");

	AST_SUMMARY_READ: assert property (
		setup_ph && !apb_i.pwrite && aligned && idx == IDX_ALARM_SUMMARY |=>
		apb_o.prdata == {31'h00000000, $past(pending_alarm)})
		else $error("summary register read disagrees with summary");

	AST_TRIM_A_IDLE: assert property (
		!mode_i.dual_channel && !(mode_i.fg_cal_en && mode_i.sample_input_pair_a) |=>
		!trim_o.a_valid)
		else $error("core A trim marked valid outside its modes");

	AST_TRIM_B_IDLE: assert property (
		!(mode_i.dual_channel && mode_i.fg_cal_en) |=> !trim_o.b_valid)
		else $error("core B trim marked valid outside its mode");

endmodule

// file: bench/alarm_mask_and_timing_trim_regs_tb.sv
`timescale 1ns/1ps
module alarm_mask_and_timing_trim_regs_tb
	import alarm_trim_pkg::*;
;
	typedef struct {
		string nm;
		logic [32:0] v;
	} note_s;
	note_s notes[$];
	int err_total = 0;
	int total_checks = 0;
	logic clk_i;
	logic rst_i;
	logic probe;
	apb_req_s req;
	apb_rsp_s rsp;
	logic [4:0] src;
	logic [15:0] lane;
	trim_fuse_s fuse;
	conv_mode_s mode;
	trim_out_s trim;
	logic summ;
	logic [7:0] t_ad;
	logic [7:0] t_bd;
	logic [7:0] t_as;
	logic [15:0] p;
	logic [15:0] w;

	alarm_mask_and_timing_trim_regs dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.apb_i(req),
		.apb_o(rsp),
		.alarm_src_i(src),
		.lane_fifo_err_i(lane),
		.fuse_i(fuse),
		.mode_i(mode),
		.trim_o(trim),
		.summary_alarm_o(summ)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	task automatic take(input logic [32:0] got);
		note_s n;
		total_checks++;
		if (notes.size() == 0) begin
			err_total++;
			$display("MISMATCH unexpected result expected none seen %h", got);
		end else begin
			n = notes.pop_front();
			if (got !== n.v) begin
				err_total++;
				$display("MISMATCH %s expected %h seen %h", n.nm, n.v, got);
			end
		end
	endtask

	always @(posedge clk_i) begin
		if (req.psel && req.penable && rsp.pready === 1'b1 && req.pwrite === 1'b0) begin
			take({rsp.pslverr, rsp.prdata});
		end
		if (probe) begin
			take({14'h0, summ, trim});
		end
	end

	// ----------------------------------------------------------------
	// Drivers, each entered and left just after a rising edge
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
		input bit hold);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= ad;
		req.pwdata <= wd;
		@(posedge clk_i);
		req.penable <= 1'b1;
		@(posedge clk_i);
		while (rsp.pready !== 1'b1) begin
			@(posedge clk_i);
		end
		if (!hold) begin
			req.psel <= 1'b0;
			req.penable <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	task automatic rd(input logic [9:0] idx, input logic [32:0] e, input string nm);
		notes.push_back('{nm, e});
		apb(1'b0, {idx, 2'h0}, 32'h0, 1'b0);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, {idx, 2'h0}, d, 1'b0);
	endtask

	function automatic logic [32:0] outv(input logic s);
		logic [17:0] t;
		t = 18'h0;
		if (mode.dual_channel) begin
			t[17:9] = {1'b1, t_ad};
		end else if (mode.fg_cal_en && mode.sample_input_pair_a) begin
			t[17:9] = {1'b1, t_as};
		end
		if (mode.dual_channel && mode.fg_cal_en) begin
			t[8:0] = {1'b1, t_bd};
		end
		return {14'h0, s, t};
	endfunction

	task automatic probe_chk(input logic s);
		notes.push_back('{"summary_and_trim", outv(s)});
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic pulse(input logic [4:0] s, input logic [15:0] l);
		src <= s;
		lane <= l;
		@(posedge clk_i);
		src <= 5'h0;
		lane <= 16'h0;
		@(posedge clk_i);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		$display("MISMATCH watchdog expected finish seen timeout");
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h7A46));
		rst_i = 1'b1;
		probe = 1'b0;
		req = '0;
		src = 5'h0;
		lane = 16'h0;
		fuse = trim_fuse_s'(24'($urandom));
		mode = 3'b111;
		t_ad = fuse.a_dual;
		t_bd = fuse.b_dual;
		t_as = fuse.a_single_ina;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(IDX_ALARM_GATE, 33'h3F, "gate");
		rd(IDX_LANE_FLAGS, 33'hFFFF, "lane_flags");
		rd(IDX_TRIM_A_DUAL, {25'h0, t_ad}, "trim_a_dual");
		rd(IDX_TRIM_B_DUAL, {25'h0, t_bd}, "trim_b_dual");
		rd(IDX_TRIM_A_SINGLE_INA, {25'h0, t_as}, "trim_a_single");
		rd(10'h2C3, 33'h100000000, "unmapped");
		apb(1'b1, {IDX_ALARM_GATE, 2'h1}, 32'h0, 1'b0);
		notes.push_back('{"unaligned", 33'h100000000});
		apb(1'b0, {IDX_ALARM_GATE, 2'h2}, 32'h0, 1'b0);
		rd(IDX_ALARM_GATE, 33'h3F, "gate_kept");
		probe_chk(1'b0);
		wr(IDX_ALARM_FLAG, 32'h3F);
		wr(IDX_LANE_FLAGS, 32'hFFFF);
		for (int i = 0; i < 6; i++) begin
			pulse(5'(32'h1 << i), (i == 5) ? 16'(32'h1 << $urandom_range(15)) : 16'h0);
			wr(IDX_ALARM_GATE, 32'h3F ^ (32'h1 << i));
			probe_chk(1'b1);
			rd(IDX_ALARM_SUMMARY, 33'h1, "summary");
			wr(IDX_ALARM_GATE, 32'hC0 | (32'h1 << i));
			probe_chk(1'b0);
			rd(IDX_ALARM_SUMMARY, 33'h0, "summary");
			wr(IDX_ALARM_FLAG, 32'h1 << i);
		end
		rd(IDX_ALARM_GATE, 33'hE0, "gate");
		wr(IDX_LANE_FLAGS, 32'hFFFF);
		rd(IDX_LANE_FLAGS, 33'h0, "lane_flags");
		p = 16'($urandom) | 16'h1;
		pulse(5'h0, p);
		rd(IDX_LANE_FLAGS, {17'h0, p}, "lane_flags");
		rd(IDX_ALARM_FLAG, 33'h20, "status");
		w = 16'($urandom);
		wr(IDX_LANE_FLAGS, {16'h0, w});
		rd(IDX_LANE_FLAGS, {17'h0, p & ~w}, "lane_flags");
		lane <= 16'h0008;
		wr(IDX_LANE_FLAGS, 32'h8);
		lane <= 16'h0;
		rd(IDX_LANE_FLAGS, {17'h0, (p & ~w) | 16'h8}, "lane_flags");
		wr(IDX_ALARM_FLAG, 32'h20);
		rd(IDX_LANE_FLAGS, 33'h0, "lane_flags");
		rd(IDX_ALARM_FLAG, 33'h0, "status");
		t_ad = 8'($urandom);
		t_bd = 8'($urandom);
		t_as = 8'($urandom);
		apb(1'b1, {IDX_TRIM_A_DUAL, 2'h0}, {24'h0, t_ad}, 1'b1);
		apb(1'b1, {IDX_TRIM_B_DUAL, 2'h0}, {24'h0, t_bd}, 1'b1);
		wr(IDX_TRIM_A_SINGLE_INA, {24'h0, t_as});
		rd(IDX_TRIM_A_DUAL, {25'h0, t_ad}, "trim_a_dual");
		rd(IDX_TRIM_B_DUAL, {25'h0, t_bd}, "trim_b_dual");
		rd(IDX_TRIM_A_SINGLE_INA, {25'h0, t_as}, "trim_a_single");
		for (int m = 0; m < 8; m++) begin
			mode <= conv_mode_s'(3'(m));
			@(posedge clk_i);
			probe_chk(1'b0);
		end
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(IDX_ALARM_GATE, 33'h3F, "gate_after_reset");
		rd(IDX_LANE_FLAGS, 33'hFFFF, "lanes_after_reset");
		rd(IDX_TRIM_B_DUAL, {25'h0, fuse.b_dual}, "trim_b_after_reset");
		give_verdict();
	end
endmodule
